// File: hdl/anl_notify_latch.sv
// asynchronous notification latch with axi4-lite register slave
module anl_notify_latch (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic clkEn,
   input wire logic [3:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [3:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic sdbValid,
   input wire logic [3:0] multiplierTargetField,
   input wire logic sdbIntrBit,
   input wire logic sdbNotifyBit,
   input wire logic otherFrameValid,
   output logic postFrame,
   output logic updateTaskFile,
   output logic intrOut
);
   logic [anl_pkg::NUM_TGT-1:0] asyncNotifyLatch_r;
   logic [anl_pkg::ST_W-1:0] status_r;
   logic [anl_pkg::ST_W-1:0] mask_r;
   logic cmdSwitch_r;
   logic [anl_pkg::TGT_W-1:0] curTarget_r;
   logic [3:0] awAddr_r;
   logic awHave_r;
   logic [31:0] wData_r;
   logic [3:0] wStrb_r;
   logic wHave_r;
   logic wrFire;
   logic tgtMatch;
   logic anyFrame;
   logic [anl_pkg::TGT_W-1:0] frameTgt;
   logic dropFrame;
   logic setSdb;
   logic setWrong;
   logic [anl_pkg::NUM_TGT-1:0] latchSet;
   logic [anl_pkg::NUM_TGT-1:0] latchClr;
   logic [anl_pkg::ST_W-1:0] stClr;
   logic [31:0] rdVal;
   logic rdOk;

   ////////////////////////////////////////////////////////////////////////////
   // frame decode
   assign frameTgt = multiplierTargetField;
   assign anyFrame = sdbValid | otherFrameValid;
   assign tgtMatch = frameTgt == curTarget_r;
   // mismatch under command switching drops the frame, notify or not
   assign dropFrame = cmdSwitch_r & ~tgtMatch;
   // notification bypasses the target check for latch and sdb status
   assign setSdb = sdbValid & sdbIntrBit & (sdbNotifyBit | ~dropFrame);
   // wrong-target status only for non-notifying frames
   assign setWrong = anyFrame & dropFrame & ~(sdbValid & sdbNotifyBit);

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         postFrame <= 1'b0;
         updateTaskFile <= 1'b0;
      end else if (clkEn) begin
         postFrame <= anyFrame & ~dropFrame;
         updateTaskFile <= sdbValid & ~dropFrame;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // notification latch, one sticky bit per target
   assign wrFire = awHave_r & wHave_r & ~bvalid;

   genvar gi;
   generate
      for (gi = 0; gi < anl_pkg::NUM_TGT; gi++) begin : g_tgt
         localparam logic [anl_pkg::TGT_W-1:0] TGT_ID = (anl_pkg::TGT_W)'(gi);
         assign latchSet[gi] = sdbValid & sdbNotifyBit &
            (frameTgt == TGT_ID);
         assign latchClr[gi] = wrFire & (awAddr_r == anl_pkg::OFS_LATCH) &
            wStrb_r[gi/8] & wData_r[gi];
      end
   endgenerate

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         asyncNotifyLatch_r <= '0;
      end else if (clkEn) begin
         // set wins over a same-cycle clear; other targets are untouched
         asyncNotifyLatch_r <= (asyncNotifyLatch_r & ~latchClr) | latchSet;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // interrupt status, write one to clear
   assign stClr = (wrFire & (awAddr_r == anl_pkg::OFS_STATUS) & wStrb_r[0]) ?
      wData_r[anl_pkg::ST_W-1:0] : '0;

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         status_r <= '0;
      end else if (clkEn) begin
         status_r[anl_pkg::ST_SDB] <= (status_r[anl_pkg::ST_SDB] &
            ~stClr[anl_pkg::ST_SDB]) | setSdb;
         status_r[anl_pkg::ST_WRONG] <= (status_r[anl_pkg::ST_WRONG] &
            ~stClr[anl_pkg::ST_WRONG]) | setWrong;
      end
   end

   assign intrOut = |(status_r & mask_r);

   ////////////////////////////////////////////////////////////////////////////
   // control registers
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         mask_r <= '0;
         cmdSwitch_r <= 1'b0;
         curTarget_r <= '0;
      end else if (clkEn && wrFire && wStrb_r[0]) begin
         if (awAddr_r == anl_pkg::OFS_MASK) begin
            mask_r <= wData_r[anl_pkg::ST_W-1:0];
         end
         if (awAddr_r == anl_pkg::OFS_CTRL) begin
            cmdSwitch_r <= wData_r[anl_pkg::CTL_CBS];
            curTarget_r <= wData_r[anl_pkg::CTL_TGT_LSB +: anl_pkg::TGT_W];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // axi4-lite write path: address and data taken in either order
   assign awready = ~awHave_r;
   assign wready = ~wHave_r;

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         awHave_r <= 1'b0;
         awAddr_r <= '0;
         wHave_r <= 1'b0;
         wData_r <= '0;
         wStrb_r <= '0;
         bvalid <= 1'b0;
         bresp <= anl_pkg::RESP_OKAY;
      end else if (clkEn) begin
         if (awvalid && awready) begin
            awHave_r <= 1'b1;
            awAddr_r <= awaddr;
         end
         if (wvalid && wready) begin
            wHave_r <= 1'b1;
            wData_r <= wdata;
            wStrb_r <= wstrb;
         end
         if (wrFire) begin
            awHave_r <= 1'b0;
            wHave_r <= 1'b0;
            bvalid <= 1'b1;
            bresp <= anl_pkg::RESP_OKAY;
         end else if (bvalid && bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // axi4-lite read path
   always_comb begin
      rdVal = '0;
      rdOk = 1'b1;
      case (araddr)
         anl_pkg::OFS_LATCH: rdVal[anl_pkg::NUM_TGT-1:0] = asyncNotifyLatch_r;
         anl_pkg::OFS_STATUS: rdVal[anl_pkg::ST_W-1:0] = status_r;
         anl_pkg::OFS_MASK: rdVal[anl_pkg::ST_W-1:0] = mask_r;
         anl_pkg::OFS_CTRL: begin
            rdVal[anl_pkg::CTL_CBS] = cmdSwitch_r;
            rdVal[anl_pkg::CTL_TGT_LSB +: anl_pkg::TGT_W] = curTarget_r;
            rdVal[anl_pkg::CAP_BIT] = 1'b1;
         end
         default: rdOk = 1'b0;
      endcase
   end

   assign arready = ~rvalid;

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         rvalid <= 1'b0;
         rdata <= '0;
         rresp <= anl_pkg::RESP_OKAY;
      end else if (clkEn) begin
         if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata <= rdVal;
            rresp <= rdOk ? anl_pkg::RESP_OKAY : anl_pkg::RESP_SLVERR;
         end else if (rvalid && rready) begin
            rvalid <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   notify_latch_a: assert property (@(posedge core_clk) disable iff (!nrst)
      clkEn && sdbValid && sdbNotifyBit
      |=> asyncNotifyLatch_r[$past(frameTgt)])
      else $error("notify frame did not set latch bit");

   target_zero_a: assert property (@(posedge core_clk) disable iff (!nrst)
      clkEn && sdbValid && sdbNotifyBit && multiplierTargetField == 4'h0
      |=> asyncNotifyLatch_r[0])
      else $error("target zero did not set bit 0");

   target_field_a: assert property (@(posedge core_clk) disable iff (!nrst)
      clkEn && sdbValid && sdbNotifyBit && !wrFire
      |=> asyncNotifyLatch_r == ($past(asyncNotifyLatch_r) | (16'h1 << $past(frameTgt))))
      else $error("latch bit not at frame target");

   sdb_status_a: assert property (@(posedge core_clk) disable iff (!nrst)
      clkEn && sdbValid && sdbIntrBit && sdbNotifyBit
      |=> status_r[anl_pkg::ST_SDB])
      else $error("sdb status not set");

   plain_sdb_a: assert property (@(posedge core_clk) disable iff (!nrst)
      clkEn && sdbValid && sdbIntrBit && !(cmdSwitch_r && !tgtMatch)
      |=> status_r[anl_pkg::ST_SDB])
      else $error("accepted sdb frame did not set status");

   no_sdb_drop_a: assert property (@(posedge core_clk) disable iff (!nrst)
      clkEn && !status_r[anl_pkg::ST_SDB] && !(sdbValid && sdbIntrBit)
      |=> !status_r[anl_pkg::ST_SDB])
      else $error("sdb status set without interrupt frame");

   drop_sdb_quiet_a: assert property (@(posedge core_clk) disable iff (!nrst)
      clkEn && !status_r[anl_pkg::ST_SDB] && sdbValid && !sdbNotifyBit && cmdSwitch_r && !tgtMatch
      |=> !status_r[anl_pkg::ST_SDB])
      else $error("dropped frame set sdb status");

   no_wrong_notify_a: assert property (@(posedge core_clk) disable iff (!nrst)
      clkEn && sdbValid && sdbNotifyBit && !otherFrameValid && !status_r[anl_pkg::ST_WRONG]
      |=> !status_r[anl_pkg::ST_WRONG])
      else $error("wrong-target status set by notify frame");

   wrong_set_a: assert property (@(posedge core_clk) disable iff (!nrst)
      clkEn && anyFrame && cmdSwitch_r && !tgtMatch && !(sdbValid && sdbNotifyBit)
      |=> status_r[anl_pkg::ST_WRONG])
      else $error("wrong-target status not set");

   wrong_quiet_a: assert property (@(posedge core_clk) disable iff (!nrst)
      clkEn && !status_r[anl_pkg::ST_WRONG] && !(anyFrame && cmdSwitch_r && !tgtMatch)
      |=> !status_r[anl_pkg::ST_WRONG])
      else $error("wrong-target status set without mismatch");

   drop_mismatch_a: assert property (@(posedge core_clk) disable iff (!nrst)
      clkEn && cmdSwitch_r && anyFrame && !tgtMatch
      |=> !postFrame && !updateTaskFile)
      else $error("mismatched frame was processed");

   notify_drop_a: assert property (@(posedge core_clk) disable iff (!nrst)
      clkEn && sdbValid && sdbNotifyBit && cmdSwitch_r && !tgtMatch
      |=> !updateTaskFile)
      else $error("mismatched notify frame updated task file");

   match_post_a: assert property (@(posedge core_clk) disable iff (!nrst)
      clkEn && sdbValid && (!cmdSwitch_r || tgtMatch)
      |=> postFrame && updateTaskFile)
      else $error("matching frame not processed");

   other_post_a: assert property (@(posedge core_clk) disable iff (!nrst)
      clkEn && otherFrameValid && !sdbValid && (!cmdSwitch_r || tgtMatch)
      |=> postFrame && !updateTaskFile)
      else $error("accepted plain frame handled wrongly");

   idle_quiet_a: assert property (@(posedge core_clk) disable iff (!nrst)
      clkEn && !anyFrame
      |=> !postFrame && !updateTaskFile)
      else $error("frame processing without a frame");

   ////////////////////////////////////////////////////////////////////////////
   // latch and interrupt checks
   latch_sticky_a: assert property (@(posedge core_clk) disable iff (!nrst)
      clkEn && !wrFire
      |=> (asyncNotifyLatch_r & $past(asyncNotifyLatch_r)) == $past(asyncNotifyLatch_r))
      else $error("latch bit lost without clear");

   latch_clear_a: assert property (@(posedge core_clk) disable iff (!nrst)
      clkEn && |latchClr && !sdbValid
      |=> (asyncNotifyLatch_r & $past(latchClr)) == '0)
      else $error("latch bit not cleared by write");

   set_wins_a: assert property (@(posedge core_clk) disable iff (!nrst)
      clkEn && |(latchSet & latchClr)
      |=> (asyncNotifyLatch_r & $past(latchSet)) == $past(latchSet))
      else $error("clear beat a same-cycle notification");

   latch_quiet_a: assert property (@(posedge core_clk) disable iff (!nrst)
      clkEn && !sdbValid && !wrFire
      |=> $stable(asyncNotifyLatch_r))
      else $error("latch changed without frame or write");

   one_target_a: assert property (@(posedge core_clk) disable iff (!nrst)
      clkEn
      |=> $countones(asyncNotifyLatch_r & ~$past(asyncNotifyLatch_r)) <= 1)
      else $error("more than one latch bit set at once");

   intr_sdb_a: assert property (@(posedge core_clk) disable iff (!nrst)
      clkEn && mask_r[anl_pkg::ST_SDB] && sdbValid && sdbIntrBit && sdbNotifyBit
      |=> intrOut)
      else $error("enabled sdb interrupt not raised");

   intr_masked_a: assert property (@(posedge core_clk) disable iff (!nrst)
      mask_r == '0
      |-> !intrOut)
      else $error("interrupt raised while all masked");

   status_clear_a: assert property (@(posedge core_clk) disable iff (!nrst)
      clkEn && wrFire && awAddr_r == anl_pkg::OFS_STATUS && wStrb_r[0] && wData_r[0] && !sdbValid
      |=> !status_r[anl_pkg::ST_SDB])
      else $error("sdb status not cleared by write");

   ////////////////////////////////////////////////////////////////////////////
   // register bus checks
   cap_bit_a: assert property (@(posedge core_clk) disable iff (!nrst)
      clkEn && arvalid && arready && araddr == anl_pkg::OFS_CTRL
      |=> rdata[anl_pkg::CAP_BIT])
      else $error("capability bit not one");

   bad_addr_a: assert property (@(posedge core_clk) disable iff (!nrst)
      clkEn && arvalid && arready && araddr[1:0] != 2'h0
      |=> rresp == anl_pkg::RESP_SLVERR && rdata == '0)
      else $error("misaligned read not refused");

   write_resp_a: assert property (@(posedge core_clk) disable iff (!nrst)
      clkEn && wrFire
      |=> bvalid && bresp == anl_pkg::RESP_OKAY)
      else $error("write response missing");

   bvalid_hold_a: assert property (@(posedge core_clk) disable iff (!nrst)
      clkEn && bvalid && !bready
      |=> bvalid && $stable(bresp))
      else $error("write response dropped early");

   rvalid_hold_a: assert property (@(posedge core_clk) disable iff (!nrst)
      clkEn && rvalid && !rready
      |=> rvalid && $stable(rdata) && $stable(rresp))
      else $error("read response dropped early");

   read_answer_a: assert property (@(posedge core_clk) disable iff (!nrst)
      clkEn && arvalid && arready
      |=> rvalid)
      else $error("read answer missing");
endmodule

// File: hdl/anl_pkg.sv
// constants and register map for the asynchronous notification latch
package anl_pkg;
   localparam int ADDR_W = 4;
   localparam logic [ADDR_W-1:0] OFS_LATCH = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h4;
   localparam logic [ADDR_W-1:0] OFS_MASK = 4'h8;
   localparam logic [ADDR_W-1:0] OFS_CTRL = 4'hc;
   localparam int TGT_W = 4;
   localparam int NUM_TGT = 16;
   localparam int ST_SDB = 0;
   localparam int ST_WRONG = 1;
   localparam int ST_W = 2;
   localparam int CTL_CBS = 0;
   localparam int CTL_TGT_LSB = 4;
   localparam int CAP_BIT = 31;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// File: test/anl_frame_source.sv
// frame source standing in for the device or port multiplier
module anl_frame_source (
   input wire logic core_clk,
   input wire logic go,
   input wire logic isSdb,
   input wire logic [3:0] tgt,
   input wire logic iBit,
   input wire logic nBit,
   output logic sdbValid = 1'b0,
   output logic [3:0] multiplierTargetField = 4'h0,
   output logic sdbIntrBit = 1'b0,
   output logic sdbNotifyBit = 1'b0,
   output logic otherFrameValid = 1'b0
);
   timeunit 1ns;
   timeprecision 1ns;
   ////////////////////////////////////////
   // fields toggle between frames so stale values are never mistaken for a frame
   always @(posedge core_clk) begin
      sdbValid <= go && isSdb;
      otherFrameValid <= go && !isSdb;
      multiplierTargetField <= go ? tgt : ~multiplierTargetField;
      sdbIntrBit <= go ? iBit : ~sdbIntrBit;
      sdbNotifyBit <= go ? nBit : ~sdbNotifyBit;
   end
endmodule

// File: test/test_sata_async_notify_latch.sv
// self-checking bench for the notification latch
module test_sata_async_notify_latch;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk = 1'b0, nrst = 1'b0, go = 1'b0, isSdb = 1'b0, iBit = 1'b0, nBit = 1'b0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [3:0] tgt = 4'h0, awaddr = 4'h0, araddr = 4'h0, cur;
   logic [31:0] wdata = 32'h0, rd, rdata;
   logic awready, wready, bvalid, arready, rvalid, sdbValid, sdbIntrBit, sdbNotifyBit;
   logic otherFrameValid, postFrame, updateTaskFile, intrOut, cbs, ri, rn;
   logic [1:0] bresp, rresp, rr, expStat, mask;
   logic [3:0] multiplierTargetField;
   logic [15:0] expLatch, v;
   int err_total = 0, cmp_count = 0, postCnt = 0, updCnt = 0, expPost = 0, expUpd = 0;
   anl_notify_latch DUT (.core_clk, .nrst, .clkEn(1'b1), .awaddr, .awvalid, .awready, .wdata,
      .wstrb(4'hf), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
      .rdata, .rresp, .rvalid, .rready, .sdbValid, .multiplierTargetField, .sdbIntrBit,
      .sdbNotifyBit, .otherFrameValid, .postFrame, .updateTaskFile, .intrOut);
   anl_frame_source partner (.core_clk, .go, .isSdb, .tgt, .iBit, .nBit, .sdbValid,
      .multiplierTargetField, .sdbIntrBit, .sdbNotifyBit, .otherFrameValid);
   initial forever #4 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      postCnt += int'(postFrame);
      updCnt += int'(updateTaskFile);
   end
   ////////////////////////////////////////
   task automatic summarize;
      $display("compares %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wrReg(input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge core_clk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
         n++;
      end while (bvalid !== 1'b1 && n < 40);
      bready <= 1'b0;
      chk("bresp", {30'h0, anl_pkg::RESP_OKAY}, {30'h0, bresp});
      if (n >= 40) err_total++;
      if (n >= 40) summarize();
   endtask
   task automatic rdReg(input logic [3:0] a);
      int n;
      n = 0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge core_clk);
         if (arready === 1'b1) arvalid <= 1'b0;
         n++;
      end while (rvalid !== 1'b1 && n < 40);
      rready <= 1'b0;
      rd = rdata;
      rr = rresp;
      if (n >= 40) err_total++;
      if (n >= 40) summarize();
   endtask
   // a frame is dropped only under command switching with a foreign target
   function automatic logic dropped(input logic [3:0] t);
      return cbs && t != cur;
   endfunction
   task automatic frame(input logic s, input logic [3:0] t, input logic i, input logic n);
      logic d;
      d = dropped(t);
      isSdb <= s;
      tgt <= t;
      iBit <= i;
      nBit <= n;
      go <= 1'b1;
      @(posedge core_clk);
      go <= 1'b0;
      repeat (3) @(posedge core_clk);
      if (s && n) expLatch[t] = 1'b1;
      if (s && i && (n || !d)) expStat[0] = 1'b1;
      if (d && !(s && n)) expStat[1] = 1'b1;
      if (!d) expPost++;
      if (s && !d) expUpd++;
   endtask
   task automatic checkAll;
      rdReg(anl_pkg::OFS_LATCH);
      chk("latch", {16'h0, expLatch}, rd);
      rdReg(anl_pkg::OFS_STATUS);
      chk("status", {30'h0, expStat}, rd);
      chk("intrOut", {31'h0, |(expStat & mask)}, {31'h0, intrOut});
      chk("post", expPost, postCnt);
      chk("taskfile", expUpd, updCnt);
   endtask
   ////////////////////////////////////////
   initial begin
      void'($urandom(47661));
      {expLatch, expStat, mask, cbs, cur} = '0;
      repeat (5) @(posedge core_clk);
      nrst <= 1'b1;
      @(posedge core_clk);
      checkAll();
      rdReg(anl_pkg::OFS_CTRL);
      chk("capability", 32'h1, {31'h0, rd[anl_pkg::CAP_BIT]});
      rdReg(4'h2);
      chk("unmapped", {30'h0, anl_pkg::RESP_SLVERR}, {30'h0, rr});
      $display("test reset done");
      frame(1'b1, 4'h0, 1'b1, 1'b1);
      checkAll();
      wrReg(anl_pkg::OFS_MASK, 32'h1);
      mask = 2'h1;
      checkAll();
      wrReg(anl_pkg::OFS_STATUS, 32'h1);
      expStat = 2'h0;
      checkAll();
      $display("test direct done");
      for (int k = 0; k < 12; k++) frame(1'b1, 4'($urandom), 1'b1, 1'b1);
      frame(1'b1, 4'hf, 1'b1, 1'b1);
      checkAll();
      v = 16'($urandom);
      wrReg(anl_pkg::OFS_LATCH, {16'h0, v});
      expLatch &= ~v;
      checkAll();
      $display("test accumulate done");
      cur = 4'h5;
      cbs = 1'b1;
      wrReg(anl_pkg::OFS_CTRL, 32'h51);
      wrReg(anl_pkg::OFS_MASK, 32'h3);
      mask = 2'h3;
      frame(1'b1, 4'h6, 1'b1, 1'b1);
      frame(1'b1, 4'h5, 1'b1, 1'b1);
      checkAll();
      for (int k = 0; k < 24; k++) begin
         rn = 1'($urandom);
         ri = rn | 1'($urandom);
         frame(rn | 1'($urandom), 4'($urandom % 8), ri, rn);
      end
      checkAll();
      $display("test switching done");
      summarize();
   end
endmodule
